// *** common/uls_pkg.sv ***
// constants for the uart line status block
// Function
// R1: status bit 7 set while receive FIFO holds any error-tagged character
// R2: status bit 7 clears once no held character carries an error tag
// R3: without FIFOs, bit 6 high when holding and shift registers both empty
// R4: transmitter-empty low while holding or shift register holds a character
// R5: with FIFOs, transmitter-empty only when tx FIFO and shift reg empty
// R6: without FIFOs, bit 5 sets when character moves holding to shift
// R7: holding-register-empty clears when host writes the holding register
// R8: interrupt request while holding-register-empty set and enable on
// R9: with FIFOs, bit 5 sets when tx FIFO empties, clears on any write
// R10: bit 4 set when serial input stays low a full character frame
// R11: each break condition loads exactly one break character
// R12: bit 3 framing error low by default and for clean characters
// R13: bit 3 set for missing stop bit; follows receive FIFO head
// R14: line status register is read-only; host writes change nothing
package uls_pkg;
  // ===========================================================
  // register offsets
  localparam logic [2:0] OFF_DATA   = 3'h0;
  localparam logic [2:0] OFF_CTRL   = 3'h1;
  localparam logic [2:0] OFF_STATUS = 3'h5;
  // ===========================================================
  // control fields and reset values
  localparam int CTRL_FIFO_EN  = 0;
  localparam int CTRL_THRE_IEN = 1;
  localparam logic [1:0] CTRL_RST = 2'h0;
  // ===========================================================
  // status field positions
  localparam int ST_FIFO_ERR = 7;
  localparam int ST_TEMT     = 6;
  localparam int ST_THRE     = 5;
  localparam int ST_BREAK    = 4;
  localparam int ST_FRAME    = 3;
  // ===========================================================
  // receive tag layout
  localparam int TAG_PAR = 0;
  localparam int TAG_FRM = 1;
  localparam int TAG_BRK = 2;
  localparam logic [2:0] TAG_BREAK_CHAR = 3'h4;
  // ===========================================================
  // timing
  localparam int CLK_PERIOD_NS = 5;
  localparam int BIT_TIME_NS   = 8680;
  localparam int FRAME_BITS    = 10;
  localparam int BIT_CYCLES    = BIT_TIME_NS / CLK_PERIOD_NS;
  localparam int FRAME_CYCLES  = FRAME_BITS * BIT_CYCLES;
endpackage

// *** hw/uls_line_status.sv ***
// line status flags with tx occupancy and rx error tag tracking
`timescale 1ns/1ps
module uls_line_status #(
  parameter int RX_DEPTH  = 16,
  parameter int TX_DEPTH  = 16,
  parameter int BRK_CYCLES = uls_pkg::FRAME_CYCLES
) (
  input  wire logic       i_core_clk,
  input  wire logic       i_resetn,
  input  wire logic [2:0] i_addr,
  input  wire logic [7:0] i_wdata,
  input  wire logic       i_wr,
  input  wire logic       i_rd,
  output logic      [7:0] o_rdata,
  input  wire logic       i_tx_load,
  input  wire logic       i_tx_done,
  output logic            o_tx_pending,
  output logic      [7:0] o_tx_byte,
  input  wire logic       i_rx_valid,
  input  wire logic [7:0] i_rx_data,
  input  wire logic       i_rx_par_err,
  input  wire logic       i_rx_frm_err,
  input  wire logic       i_rx_serial,
  output logic            o_irq
);
  localparam int RAW = $clog2(RX_DEPTH);
  localparam int TAW = $clog2(TX_DEPTH);
  localparam int BCW = $clog2(BRK_CYCLES + 1);

  logic [1:0]     ctrl_ff;
  logic [7:0]     rdata_ff;
  logic [TAW:0]   tx_cnt_ff;
  logic [TAW:0]   nxt_tx_cnt;
  logic [TAW-1:0] tx_wp_ff;
  logic [TAW-1:0] tx_rp_ff;
  logic [7:0]     tx_mem [TX_DEPTH];
  logic           shift_busy_ff;
  logic           thre_ff;
  logic [RAW:0]   rx_cnt_ff;
  logic [RAW:0]   err_cnt_ff;
  logic [RAW-1:0] rx_wp_ff;
  logic [RAW-1:0] rx_rp_ff;
  logic [10:0]    rx_mem [RX_DEPTH];
  logic           rx_meta_ff;
  logic           rx_sync_ff;
  logic [BCW-1:0] brk_cnt_ff;
  logic           brk_done_ff;
  logic           brk_push;
  logic           push;
  logic           pop;
  logic [2:0]     push_tag;
  logic [7:0]     push_data;
  logic [2:0]     head_tag;
  logic           fifo_en;
  logic           wr_data;
  logic           wr_ctrl;
  logic           tx_cap;
  logic           flush;
  logic           rx_do_push;
  logic           temt;
  logic [7:0]     status;

  assign fifo_en = ctrl_ff[uls_pkg::CTRL_FIFO_EN];
  assign wr_data = i_wr && (i_addr == uls_pkg::OFF_DATA);
  assign wr_ctrl = i_wr && (i_addr == uls_pkg::OFF_CTRL);
  assign tx_cap  = fifo_en ? (tx_cnt_ff != (TAW+1)'(TX_DEPTH))
                           : (tx_cnt_ff == '0);
  assign flush   = wr_ctrl && (i_wdata[uls_pkg::CTRL_FIFO_EN] != fifo_en);

  // ===========================================================
  // control register
  // changing the fifo mode flushes both queues, as in classic parts
  always_ff @(posedge i_core_clk) begin
    if (!i_resetn) begin
      ctrl_ff <= uls_pkg::CTRL_RST;
    end else if (wr_ctrl) begin
      ctrl_ff <= i_wdata[1:0];
    end
  end

  // ===========================================================
  // transmit holding register / fifo
  // a write into a full holder is dropped; load with nothing held ignored
  always_comb begin
    nxt_tx_cnt = tx_cnt_ff;
    if (wr_data && tx_cap) begin
      nxt_tx_cnt = nxt_tx_cnt + 1'b1;
    end
    if (i_tx_load && (tx_cnt_ff != '0)) begin
      nxt_tx_cnt = nxt_tx_cnt - 1'b1;
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (!i_resetn || flush) begin
      tx_cnt_ff <= '0;
      tx_wp_ff  <= '0;
      tx_rp_ff  <= '0;
    end else begin
      tx_cnt_ff <= nxt_tx_cnt;
      if (wr_data && tx_cap) begin
        tx_wp_ff <= tx_wp_ff + 1'b1;
      end
      if (i_tx_load && (tx_cnt_ff != '0)) begin
        tx_rp_ff <= tx_rp_ff + 1'b1;
      end
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (wr_data && tx_cap) begin
      tx_mem[tx_wp_ff] <= i_wdata;
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (!i_resetn) begin
      o_tx_byte <= 8'h00;
    end else begin
      o_tx_byte <= (tx_cnt_ff != '0) ? tx_mem[tx_rp_ff] : 8'h00;
    end
  end

  // empty flag follows the holder count: sets on the move, clears on write
  always_ff @(posedge i_core_clk) begin
    if (!i_resetn || flush) begin
      thre_ff <= 1'b1;
    end else begin
      thre_ff <= (nxt_tx_cnt == '0); // [R6] [R7] [R9]
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (!i_resetn) begin
      shift_busy_ff <= 1'b0;
    end else if (i_tx_load && (tx_cnt_ff != '0)) begin
      shift_busy_ff <= 1'b1;
    end else if (i_tx_done) begin
      shift_busy_ff <= 1'b0;
    end
  end

  assign o_tx_pending = (tx_cnt_ff != '0);
  assign temt  = thre_ff && !shift_busy_ff; // [R3] [R4] [R5]
  assign o_irq = thre_ff && ctrl_ff[uls_pkg::CTRL_THRE_IEN]; // [R8]

  // ===========================================================
  // break detection on the synchronised serial input
  always_ff @(posedge i_core_clk) begin
    if (!i_resetn) begin
      rx_meta_ff <= 1'b1;
      rx_sync_ff <= 1'b1;
    end else begin
      rx_meta_ff <= i_rx_serial;
      rx_sync_ff <= rx_meta_ff;
    end
  end

  // one break per low period; rearmed only when the line returns high
  always_ff @(posedge i_core_clk) begin
    if (!i_resetn || rx_sync_ff) begin
      brk_cnt_ff  <= '0;
      brk_done_ff <= 1'b0;
    end else if (!brk_done_ff) begin
      if (brk_cnt_ff == BCW'(BRK_CYCLES - 1)) begin
        brk_done_ff <= 1'b1; // [R10] [R11]
      end else begin
        brk_cnt_ff <= brk_cnt_ff + 1'b1;
      end
    end
  end

  assign brk_push = !rx_sync_ff && !brk_done_ff
                    && (brk_cnt_ff == BCW'(BRK_CYCLES - 1));

  // ===========================================================
  // receive queue of data and error tags
  // break has priority; a character in the same cycle is lost
  assign push      = brk_push || i_rx_valid;
  assign push_tag  = brk_push ? uls_pkg::TAG_BREAK_CHAR
                              : {1'b0, i_rx_frm_err, i_rx_par_err};
  assign push_data = brk_push ? 8'h00 : i_rx_data;
  assign rx_do_push = push && (!fifo_en || pop
                               || (rx_cnt_ff != (RAW+1)'(RX_DEPTH)));
  assign pop  = i_rd && (i_addr == uls_pkg::OFF_DATA) && (rx_cnt_ff != '0);
  assign head_tag = (rx_cnt_ff != '0) ? rx_mem[rx_rp_ff][10:8] : 3'h0;

  always_ff @(posedge i_core_clk) begin
    // a dropped push into a full fifo must not land on the head entry
    if (rx_do_push) begin
      rx_mem[fifo_en ? rx_wp_ff : rx_rp_ff] <= {push_tag, push_data};
    end
  end

  // without fifos the single holder is overwritten; full fifo drops push unless a pop frees a slot
  always_ff @(posedge i_core_clk) begin
    if (!i_resetn || flush) begin
      rx_cnt_ff  <= '0;
      err_cnt_ff <= '0;
      rx_wp_ff   <= '0;
      rx_rp_ff   <= '0;
    end else if (!fifo_en) begin
      if (push) begin
        rx_cnt_ff  <= (RAW+1)'(1);
        err_cnt_ff <= (RAW+1)'(push_tag != 3'h0);
      end else if (pop) begin
        rx_cnt_ff  <= '0;
        err_cnt_ff <= '0;
      end
    end else begin
      if (rx_do_push) begin
        rx_wp_ff <= rx_wp_ff + 1'b1;
      end
      if (pop) begin
        rx_rp_ff <= rx_rp_ff + 1'b1;
      end
      rx_cnt_ff <= rx_cnt_ff + (RAW+1)'(rx_do_push) - (RAW+1)'(pop);
      err_cnt_ff <= err_cnt_ff
                    + (RAW+1)'(rx_do_push && (push_tag != 3'h0))
                    - (RAW+1)'(pop && (head_tag != 3'h0)); // [R1] [R2]
    end
  end

  // ===========================================================
  // status and read port; status address ignores writes
  always_comb begin
    status = 8'h00;
    status[uls_pkg::ST_FIFO_ERR] = (err_cnt_ff != '0); // [R1] [R2]
    status[uls_pkg::ST_TEMT]     = temt;
    status[uls_pkg::ST_THRE]     = thre_ff;
    status[uls_pkg::ST_BREAK]    = head_tag[uls_pkg::TAG_BRK]; // [R10]
    status[uls_pkg::ST_FRAME]    = head_tag[uls_pkg::TAG_FRM]; // [R12] [R13]
  end

  always_ff @(posedge i_core_clk) begin
    if (!i_resetn) begin
      rdata_ff <= 8'h00;
    end else if (i_rd) begin
      unique case (i_addr)
        uls_pkg::OFF_DATA:
          rdata_ff <= (rx_cnt_ff != '0) ? rx_mem[rx_rp_ff][7:0] : 8'h00;
        uls_pkg::OFF_CTRL:   rdata_ff <= {6'h00, ctrl_ff};
        uls_pkg::OFF_STATUS: rdata_ff <= status; // [R14]
        default:             rdata_ff <= 8'h00;
      endcase
    end else begin
      rdata_ff <= 8'h00;
    end
  end

  assign o_rdata = rdata_ff;

  // ===========================================================
  // checks
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (!i_resetn);

  property p_err_set;
    fifo_en && i_rx_valid && !brk_push && i_rx_par_err
      && (rx_cnt_ff == '0) && !pop && !wr_ctrl
      |=> status[uls_pkg::ST_FIFO_ERR];
  endproperty
  a_err_set: assert property (p_err_set) // [R1]
    else $error("error flag not set by tagged char");

  property p_err_clr;
    (rx_cnt_ff == '0) |-> !status[uls_pkg::ST_FIFO_ERR];
  endproperty
  a_err_clr: assert property (p_err_clr) // [R2]
    else $error("error flag set with empty queue");

  property p_temt_busy;
    shift_busy_ff || (tx_cnt_ff != '0) |-> !status[uls_pkg::ST_TEMT];
  endproperty
  a_temt_busy: assert property (p_temt_busy) // [R4]
    else $error("tx empty while character held");

  property p_temt_idle;
    !i_tx_load && !wr_data ##1 (tx_cnt_ff == '0) && !shift_busy_ff
      |-> status[uls_pkg::ST_TEMT];
  endproperty
  a_temt_idle: assert property (p_temt_idle) // [R3] [R5]
    else $error("tx empty missing");

  property p_thre_set;
    !fifo_en && i_tx_load && (tx_cnt_ff == 1) && !wr_data
      |=> thre_ff && !temt;
  endproperty
  a_thre_set: assert property (p_thre_set) // [R6]
    else $error("holding empty not set on move");

  property p_thre_clr;
    wr_data && tx_cap && !wr_ctrl |=> !thre_ff ##1 1'b1;
  endproperty
  a_thre_clr: assert property (p_thre_clr) // [R7] [R9]
    else $error("holding empty not cleared on write");

  property p_irq;
    o_irq == (thre_ff && ctrl_ff[uls_pkg::CTRL_THRE_IEN]);
  endproperty
  a_irq: assert property (p_irq) // [R8]
    else $error("irq mismatch");

  property p_brk_once;
    brk_push |=> !brk_push [*8];
  endproperty
  a_brk_once: assert property (p_brk_once) // [R11]
    else $error("second break push in one low period");

  property p_brk_flag;
    brk_push && !wr_ctrl && (rx_cnt_ff == '0)
      |=> status[uls_pkg::ST_BREAK] && (rx_cnt_ff == 1);
  endproperty
  a_brk_flag: assert property (p_brk_flag) // [R10]
    else $error("break not reported");

  property p_frm_idle;
    (rx_cnt_ff == '0) |-> !status[uls_pkg::ST_FRAME];
  endproperty
  a_frm_idle: assert property (p_frm_idle) // [R12]
    else $error("framing set with nothing held");

  property p_frm_head;
    !fifo_en && i_rx_valid && !brk_push && i_rx_frm_err && !wr_ctrl
      |=> status[uls_pkg::ST_FRAME];
  endproperty
  a_frm_head: assert property (p_frm_head) // [R13]
    else $error("framing not reported");

  c_break:   cover property (brk_push);
  c_err:     cover property ($rose(status[uls_pkg::ST_FIFO_ERR]));
  c_temt:    cover property ($rose(temt));
  c_full_tx: cover property (fifo_en && !tx_cap);
endmodule

// *** verif/uls_host.sv ***
// host processor model driving the line status register bus
`timescale 1ns/1ps
module uls_host (
  input  wire logic       i_core_clk,
  output logic      [2:0] o_addr,
  output logic      [7:0] o_wdata,
  output logic            o_wr,
  output logic            o_rd
);
  initial begin
    o_addr  = 3'h0;
    o_wdata = 8'h00;
    o_wr    = 1'b0;
    o_rd    = 1'b0;
  end
  // ==========================================================
  // single-cycle strobe, launched and dropped just after an edge
  task automatic bus(input logic [2:0] a, input logic [7:0] d,
                     input logic w);
    @(posedge i_core_clk);
    o_addr  <= a;
    o_wdata <= d;
    o_wr    <= w;
    o_rd    <= !w;
    @(posedge i_core_clk);
    o_wr    <= 1'b0;
    o_rd    <= 1'b0;
  endtask
endmodule

// *** verif/tb_top.sv ***
// self-checking bench for the line status block
`timescale 1ns/1ps
module tb_top;
  logic       i_core_clk   = 1'b0;
  logic       i_resetn     = 1'b0;
  logic       i_tx_load    = 1'b0;
  logic       i_tx_done    = 1'b0;
  logic       i_rx_valid   = 1'b0;
  logic       i_rx_par_err = 1'b0;
  logic       i_rx_frm_err = 1'b0;
  logic       i_rx_serial  = 1'b1;
  logic [7:0] i_rx_data    = 8'h00;
  logic [2:0] addr;
  logic [7:0] wdata;
  logic       wr;
  logic       rd;
  logic       rd_q         = 1'b0;
  logic [7:0] o_rdata;
  logic [7:0] o_tx_byte;
  logic       o_tx_pending;
  logic       o_irq;
  logic [31:0] rng         = 32'd9742;
  logic [7:0] b0;
  logic [7:0] b1;
  logic [7:0] exp_q[$];
  string      nm_q[$];
  int         miscompares  = 0;
  int         checks_done  = 0;

  always #2.5 i_core_clk = ~i_core_clk;

  uls_host uls_host_inst (.i_core_clk(i_core_clk), .o_addr(addr),
    .o_wdata(wdata), .o_wr(wr), .o_rd(rd));

  // short break window keeps the run small
  uls_line_status #(.BRK_CYCLES(20)) uls_line_status_inst (
    .i_core_clk(i_core_clk), .i_resetn(i_resetn), .i_addr(addr),
    .i_wdata(wdata), .i_wr(wr), .i_rd(rd), .o_rdata(o_rdata),
    .i_tx_load(i_tx_load), .i_tx_done(i_tx_done),
    .o_tx_pending(o_tx_pending), .o_tx_byte(o_tx_byte),
    .i_rx_valid(i_rx_valid), .i_rx_data(i_rx_data),
    .i_rx_par_err(i_rx_par_err), .i_rx_frm_err(i_rx_frm_err),
    .i_rx_serial(i_rx_serial), .o_irq(o_irq));

  // ==========================================================
  // helpers
  function automatic logic [7:0] xorshift();
    rng ^= rng << 13;
    rng ^= rng >> 17;
    rng ^= rng << 5;
    return rng[7:0];
  endfunction

  task automatic check(input string nm, input logic [7:0] seen, exp);
    checks_done++;
    if (seen !== exp) begin
      miscompares++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic rd_at(input string nm, input logic [2:0] a,
                       input logic [7:0] e);
    exp_q.push_back(e);
    nm_q.push_back(nm);
    uls_host_inst.bus(a, 8'h00, 1'b0);
  endtask

  task automatic rd_exp(input string nm, input logic [7:0] e);
    rd_at(nm, uls_pkg::OFF_STATUS, e);
  endtask

  task automatic pop_exp(input logic [7:0] e);
    rd_at("rx_data", uls_pkg::OFF_DATA, e);
  endtask

  task automatic wr_reg(input logic [2:0] a, input logic [7:0] d);
    uls_host_inst.bus(a, d, 1'b1);
  endtask

  // k: 0 load, 1 done, 2 rx valid
  task automatic strobe(input int k);
    @(posedge i_core_clk);
    {i_tx_load, i_tx_done, i_rx_valid} <= 3'b100 >> k;
    @(posedge i_core_clk);
    {i_tx_load, i_tx_done, i_rx_valid} <= 3'b000;
  endtask

  task automatic rx(input logic [7:0] d, input logic p, f);
    i_rx_data    <= d;
    i_rx_par_err <= p;
    i_rx_frm_err <= f;
    strobe(2);
  endtask

  task automatic settle();
    repeat (3) @(posedge i_core_clk);
    #1;
  endtask

  task automatic test_done();
    $display("checks %0d mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  // ==========================================================
  // read result watcher
  always @(posedge i_core_clk) begin
    if (rd_q && exp_q.size() > 0)
      check(nm_q.pop_front(), o_rdata, exp_q.pop_front());
    rd_q <= rd;
  end

  initial begin
    #(20000 * 5);
    miscompares++;
    test_done();
  end

  // ==========================================================
  // tests
  initial begin
    repeat (12) @(posedge i_core_clk);
    i_resetn <= 1'b1;
    rd_exp("st_reset", 8'h60);
    wr_reg(uls_pkg::OFF_STATUS, 8'h9f);
    rd_exp("st_ro", 8'h60);
    wr_reg(uls_pkg::OFF_CTRL, 8'h02);
    settle();
    check("irq_on", {7'h00, o_irq}, 8'h01);
    check("pend_idle", {7'h00, o_tx_pending}, 8'h00);
    rd_at("ctrl", uls_pkg::OFF_CTRL, 8'h02);
    rd_at("unmapped", 3'h7, 8'h00);
    wr_reg(uls_pkg::OFF_DATA, xorshift());
    settle();
    check("irq_off", {7'h00, o_irq}, 8'h00);
    check("pend_held", {7'h00, o_tx_pending}, 8'h01);
    rd_exp("st_held", 8'h00);
    strobe(0);
    rd_exp("st_moved", 8'h20);
    strobe(1);
    rd_exp("st_idle", 8'h60);
    strobe(0);
    rd_exp("st_idle_load", 8'h60);
    $display("test nonfifo_tx done");
    wr_reg(uls_pkg::OFF_CTRL, 8'h03);
    b0 = xorshift();
    b1 = xorshift();
    wr_reg(uls_pkg::OFF_DATA, b0);
    wr_reg(uls_pkg::OFF_DATA, b1);
    settle();
    check("tx_byte", o_tx_byte, b0);
    rd_exp("st_two", 8'h00);
    strobe(0);
    rd_exp("st_one", 8'h00);
    strobe(0);
    rd_exp("st_last", 8'h20);
    strobe(1);
    rd_exp("st_empty", 8'h60);
    $display("test fifo_tx done");
    b0 = xorshift();
    b1 = xorshift();
    rx(b0, 1'b0, 1'b0);
    rx(b1, 1'b0, 1'b1);
    rd_exp("st_err_behind", 8'he0);
    pop_exp(b0);
    rd_exp("st_frm_head", 8'he8);
    pop_exp(b1);
    rd_exp("st_clean", 8'h60);
    rx(b0, 1'b1, 1'b0);
    rd_exp("st_par", 8'he0);
    pop_exp(b0);
    rd_exp("st_par_gone", 8'h60);
    $display("test rx_errors done");
    i_rx_serial <= 1'b0;
    repeat (70) @(posedge i_core_clk);
    i_rx_serial <= 1'b1;
    repeat (5) @(posedge i_core_clk);
    rd_exp("st_break", 8'hf0);
    pop_exp(8'h00);
    rd_exp("st_one_break", 8'h60);
    pop_exp(8'h00);
    $display("test break done");
    wr_reg(uls_pkg::OFF_CTRL, 8'h02);
    rx(b0, 1'b0, 1'b1);
    rd_exp("st_frm_nf", 8'he8);
    rx(b1, 1'b0, 1'b0);
    rd_exp("st_frm_gone", 8'h60);
    pop_exp(b1);
    $display("test nonfifo_rx done");
    repeat (3) @(posedge i_core_clk);
    test_done();
  end
endmodule
